// ===== design/dtc_pkg.sv
package dtc_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TMR0_LOW = 8'h8a;
    localparam logic [7:0] IDX_TMR1_LOW = 8'h8b;
    localparam logic [7:0] IDX_TMR0_HIGH = 8'h8c;
    localparam logic [7:0] IDX_TMR1_HIGH = 8'h8d;

    // control register bits
    localparam int CTL_TMR1_OVF = 7;
    localparam int CTL_TMR1_RUN = 6;
    localparam int CTL_TMR0_OVF = 5;
    localparam int CTL_TMR0_RUN = 4;
    localparam int CTL_X1_FLAG = 3;
    localparam int CTL_X1_TRIG = 2;
    localparam int CTL_X0_FLAG = 1;
    localparam int CTL_X0_TRIG = 0;

    // mode register: one nibble per timer
    localparam int MODE_TMR1_LSB = 4;
    localparam int MODE_TMR0_LSB = 0;

    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [4:0] LOW5_MAX = 5'h1f;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [4:0] LOW5_ONE = 5'h01;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    typedef enum logic [1:0]
    {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } dtc_mode_type;

    typedef struct packed
    {
        logic gate;
        logic counter_sel;
        dtc_mode_type mode;
    } dtc_timer_cfg_type;

    typedef struct packed
    {
        logic low_we;
        logic high_we;
        logic [7:0] data;
    } dtc_count_wr_type;

    typedef enum logic [1:0]
    {
        BUS_WAIT = 2'b01,
        BUS_DONE = 2'b10
    } dtc_bus_state_type;

    function automatic logic [ADDR_W-1:0] word_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : word_addr

endpackage : dtc_pkg

// ===== design/dtc_timer.sv
module dtc_timer #(
    parameter bit STOP_SPLIT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input dtc_pkg::dtc_timer_cfg_type cfg_i,
    input wire logic run_i,
    input wire logic gate_pin_i,
    input wire logic count_pin_i,
    input wire logic high_step_i,
    input dtc_pkg::dtc_count_wr_type wr_i,
    output logic [7:0] low_o,
    output logic [7:0] high_o,
    output logic ovf_o,
    output logic high_ovf_o
);

    logic [7:0] low_reg;
    logic [7:0] low_next;
    logic [7:0] high_reg;
    logic [7:0] high_next;
    logic pin_reg;
    logic [15:0] word_inc;
    logic [4:0] low5_inc;
    logic [7:0] low_inc;
    logic [7:0] high_inc;

    // only a one-then-zero pair of samples counts in counter function
    wire pin_fall = pin_reg & ~count_pin_i;
    wire src_tick = cfg_i.counter_sel ? pin_fall : 1'b1;
    wire gated_on = run_i & (~cfg_i.gate | gate_pin_i);
    wire step = gated_on & src_tick;
    wire low5_full = low_reg[4:0] == dtc_pkg::LOW5_MAX;
    wire low_full = low_reg == dtc_pkg::BYTE_MAX;
    wire high_full = high_reg == dtc_pkg::BYTE_MAX;
    wire split = cfg_i.mode == dtc_pkg::MODE_SPLIT;

    assign word_inc = {high_reg, low_reg} + dtc_pkg::WORD_ONE;
    assign low5_inc = low_reg[4:0] + dtc_pkg::LOW5_ONE;
    assign low_inc = low_reg + dtc_pkg::BYTE_ONE;
    assign high_inc = high_reg + dtc_pkg::BYTE_ONE;
    assign high_ovf_o = split & high_step_i & high_full;

    always_comb
    begin
        low_next = low_reg;
        high_next = high_reg;
        ovf_o = 1'b0;
        if (step)
        begin
            unique case (cfg_i.mode)
                dtc_pkg::MODE_13BIT:
                begin
                    // upper three low bits are left alone and mean nothing
                    low_next[4:0] = low5_inc;
                    if (low5_full)
                    begin
                        high_next = high_inc;
                    end
                    ovf_o = low5_full & high_full;
                end
                dtc_pkg::MODE_16BIT:
                begin
                    {high_next, low_next} = word_inc;
                    ovf_o = low_full & high_full;
                end
                dtc_pkg::MODE_RELOAD:
                begin
                    low_next = low_full ? high_reg : low_inc;
                    ovf_o = low_full;
                end
                dtc_pkg::MODE_SPLIT:
                begin
                    if (!STOP_SPLIT)
                    begin
                        low_next = low_inc;
                        ovf_o = low_full;
                    end
                end
            endcase
        end
        if (split && high_step_i)
        begin
            high_next = high_inc;
        end
        // a software load wins over a count step in the same cycle
        if (wr_i.low_we)
        begin
            low_next = wr_i.data;
        end
        if (wr_i.high_we)
        begin
            high_next = wr_i.data;
        end
    end

    // no clear on run: counts change only by counting or loading
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low_reg <= dtc_pkg::COUNT_RST;
            high_reg <= dtc_pkg::COUNT_RST;
            pin_reg <= 1'b0;
        end
        else
        begin
            low_reg <= low_next;
            high_reg <= high_next;
            pin_reg <= count_pin_i;
        end
    end

    assign low_o = low_reg;
    assign high_o = high_reg;

endmodule : dtc_timer

// ===== design/dtc_top.sv
module dtc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic count_pin_zero_i,
    input wire logic count_pin_one_i,
    input wire logic ext_irq_pin_zero_n_i,
    input wire logic ext_irq_pin_one_n_i,
    input wire logic vector_timer_zero_i,
    input wire logic vector_timer_one_i,
    input wire logic vector_ext_irq_zero_i,
    input wire logic vector_ext_irq_one_i,
    output logic timer_zero_overflow_flag_o,
    output logic timer_one_overflow_flag_o,
    output logic ext_irq_zero_flag_o,
    output logic ext_irq_one_flag_o
);

    dtc_pkg::dtc_bus_state_type state_reg;
    dtc_pkg::dtc_bus_state_type state_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    logic [7:0] mode_reg;
    logic timer_one_run_reg;
    logic timer_zero_run_reg;
    logic ext_irq_one_trigger_type_reg;
    logic ext_irq_zero_trigger_type_reg;
    logic timer_one_overflow_flag_reg;
    logic timer_one_overflow_flag_next;
    logic timer_zero_overflow_flag_reg;
    logic timer_zero_overflow_flag_next;
    logic ext_irq_one_flag_reg;
    logic ext_irq_one_flag_next;
    logic ext_irq_zero_flag_reg;
    logic ext_irq_zero_flag_next;
    logic irq_pin_one_reg;
    logic irq_pin_zero_reg;

    logic [7:0] tmr0_low;
    logic [7:0] tmr0_high;
    logic [7:0] tmr1_low;
    logic [7:0] tmr1_high;
    logic tmr0_ovf;
    logic tmr1_ovf;
    logic tmr0_high_ovf;
    dtc_pkg::dtc_count_wr_type tmr0_wr;
    dtc_pkg::dtc_count_wr_type tmr1_wr;
    dtc_pkg::dtc_timer_cfg_type tmr0_cfg;
    dtc_pkg::dtc_timer_cfg_type tmr1_cfg;
    logic [7:0] control_view;
    logic [7:0] rd_byte;

    // set wins over both the vector clear and a software write
    function automatic logic flag_update(
        input logic set,
        input logic wr,
        input logic wbit,
        input logic flag,
        input logic clr
    );
        return set | (wr ? wbit : flag & ~clr);
    endfunction : flag_update

    function automatic logic pin_fell(
        input logic prev,
        input logic cur
    );
        return prev & ~cur;
    endfunction : pin_fell

    // level mode: the flag mirrors the pin, so only the source can clear it
    function automatic logic ext_flag_next(
        input logic edge_mode,
        input logic edge_value,
        input logic pin_n
    );
        return edge_mode ? edge_value : ~pin_n;
    endfunction : ext_flag_next

    // bus decode
    wire access = psel_i & penable_i;
    wire commit = access & pready_reg;
    wire hit_ctl = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_CONTROL);
    wire hit_mode = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_MODE);
    wire hit_tmr0_low = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_TMR0_LOW);
    wire hit_tmr1_low = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_TMR1_LOW);
    wire hit_tmr0_high = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_TMR0_HIGH);
    wire hit_tmr1_high = paddr_i == dtc_pkg::word_addr(dtc_pkg::IDX_TMR1_HIGH);
    wire hit_any = hit_ctl | hit_mode | hit_tmr0_low | hit_tmr1_low | hit_tmr0_high | hit_tmr1_high;
    // only byte lane 0 carries data; writes with lane 0 off store nothing
    wire wr_ok = commit & pwrite_i & pstrb_i[0];
    wire wr_ctl = wr_ok & hit_ctl;
    wire wr_mode = wr_ok & hit_mode;
    wire [7:0] wbyte = pwdata_i[7:0];

    // mode register split into per-timer configuration
    assign tmr0_cfg = mode_reg[dtc_pkg::MODE_TMR0_LSB +: 4];
    assign tmr1_cfg = mode_reg[dtc_pkg::MODE_TMR1_LSB +: 4];

    assign tmr0_wr.low_we = wr_ok & hit_tmr0_low;
    assign tmr0_wr.high_we = wr_ok & hit_tmr0_high;
    assign tmr0_wr.data = wbyte;
    assign tmr1_wr.low_we = wr_ok & hit_tmr1_low;
    assign tmr1_wr.high_we = wr_ok & hit_tmr1_high;
    assign tmr1_wr.data = wbyte;

    // split timer zero: its high byte counts cycles on timer one's run bit
    wire tmr0_split = tmr0_cfg.mode == dtc_pkg::MODE_SPLIT;
    wire tmr0_high_step = tmr0_split & timer_one_run_reg;

    // gate inputs take the raw pin level; the flags are not involved
    dtc_timer #(
        .STOP_SPLIT(1'b0)
    ) u_timer_zero (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(tmr0_cfg),
        .run_i(timer_zero_run_reg),
        .gate_pin_i(ext_irq_pin_zero_n_i),
        .count_pin_i(count_pin_zero_i),
        .high_step_i(tmr0_high_step),
        .wr_i(tmr0_wr),
        .low_o(tmr0_low),
        .high_o(tmr0_high),
        .ovf_o(tmr0_ovf),
        .high_ovf_o(tmr0_high_ovf)
    );

    // timer one holds its count in split mode
    dtc_timer #(
        .STOP_SPLIT(1'b1)
    ) u_timer_one (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(tmr1_cfg),
        .run_i(timer_one_run_reg),
        .gate_pin_i(ext_irq_pin_one_n_i),
        .count_pin_i(count_pin_one_i),
        .high_step_i(1'b0),
        .wr_i(tmr1_wr),
        .low_o(tmr1_low),
        .high_o(tmr1_high),
        .ovf_o(tmr1_ovf),
        .high_ovf_o()
    );

    // while timer zero is split, timer one overflows raise no flag
    wire tmr1_flag_set = tmr0_split ? tmr0_high_ovf : tmr1_ovf;

    assign timer_one_overflow_flag_next = flag_update(
        tmr1_flag_set,
        wr_ctl,
        wbyte[dtc_pkg::CTL_TMR1_OVF],
        timer_one_overflow_flag_reg,
        vector_timer_one_i
    );
    assign timer_zero_overflow_flag_next = flag_update(
        tmr0_ovf,
        wr_ctl,
        wbyte[dtc_pkg::CTL_TMR0_OVF],
        timer_zero_overflow_flag_reg,
        vector_timer_zero_i
    );

    // external interrupt pins: falling edge from one registered sample
    wire x0_fall = pin_fell(irq_pin_zero_reg, ext_irq_pin_zero_n_i);
    wire x1_fall = pin_fell(irq_pin_one_reg, ext_irq_pin_one_n_i);
    wire x0_edge_next = flag_update(
        x0_fall,
        wr_ctl,
        wbyte[dtc_pkg::CTL_X0_FLAG],
        ext_irq_zero_flag_reg,
        vector_ext_irq_zero_i
    );
    wire x1_edge_next = flag_update(
        x1_fall,
        wr_ctl,
        wbyte[dtc_pkg::CTL_X1_FLAG],
        ext_irq_one_flag_reg,
        vector_ext_irq_one_i
    );

    assign ext_irq_zero_flag_next = ext_flag_next(
        ext_irq_zero_trigger_type_reg,
        x0_edge_next,
        ext_irq_pin_zero_n_i
    );
    assign ext_irq_one_flag_next = ext_flag_next(
        ext_irq_one_trigger_type_reg,
        x1_edge_next,
        ext_irq_pin_one_n_i
    );

    assign control_view = {
        timer_one_overflow_flag_reg,
        timer_one_run_reg,
        timer_zero_overflow_flag_reg,
        timer_zero_run_reg,
        ext_irq_one_flag_reg,
        ext_irq_one_trigger_type_reg,
        ext_irq_zero_flag_reg,
        ext_irq_zero_trigger_type_reg
    };

    // read mux
    assign rd_byte = hit_ctl ? control_view :
        hit_mode ? mode_reg :
        hit_tmr0_low ? tmr0_low :
        hit_tmr1_low ? tmr1_low :
        hit_tmr0_high ? tmr0_high :
        hit_tmr1_high ? tmr1_high :
        dtc_pkg::COUNT_RST;

    // one wait state: ready comes in the second access cycle
    always_comb
    begin
        state_next = state_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        unique case (state_reg)
            dtc_pkg::BUS_WAIT:
            begin
                if (access)
                begin
                    state_next = dtc_pkg::BUS_DONE;
                    prdata_next = pwrite_i ? prdata_reg : {24'h000000, rd_byte};
                    pslverr_next = ~hit_any;
                end
            end
            dtc_pkg::BUS_DONE:
            begin
                state_next = dtc_pkg::BUS_WAIT;
                pslverr_next = 1'b0;
            end
            default:
            begin
                state_next = dtc_pkg::BUS_WAIT;
                pslverr_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= dtc_pkg::BUS_WAIT;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            state_reg <= state_next;
            pready_reg <= state_next == dtc_pkg::BUS_DONE;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // control and mode registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= dtc_pkg::MODE_RST;
            timer_one_run_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_TMR1_RUN];
            timer_zero_run_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_TMR0_RUN];
            ext_irq_one_trigger_type_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_X1_TRIG];
            ext_irq_zero_trigger_type_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_X0_TRIG];
        end
        else
        begin
            if (wr_mode)
            begin
                mode_reg <= wbyte;
            end
            if (wr_ctl)
            begin
                timer_one_run_reg <= wbyte[dtc_pkg::CTL_TMR1_RUN];
                timer_zero_run_reg <= wbyte[dtc_pkg::CTL_TMR0_RUN];
                ext_irq_one_trigger_type_reg <= wbyte[dtc_pkg::CTL_X1_TRIG];
                ext_irq_zero_trigger_type_reg <= wbyte[dtc_pkg::CTL_X0_TRIG];
            end
        end
    end

    // flags and pin history
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_one_overflow_flag_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_TMR1_OVF];
            timer_zero_overflow_flag_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_TMR0_OVF];
            ext_irq_one_flag_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_X1_FLAG];
            ext_irq_zero_flag_reg <= dtc_pkg::CONTROL_RST[dtc_pkg::CTL_X0_FLAG];
            // idle pins sit high, so a pin held low at release counts as an edge
            irq_pin_one_reg <= 1'b1;
            irq_pin_zero_reg <= 1'b1;
        end
        else
        begin
            timer_one_overflow_flag_reg <= timer_one_overflow_flag_next;
            timer_zero_overflow_flag_reg <= timer_zero_overflow_flag_next;
            ext_irq_one_flag_reg <= ext_irq_one_flag_next;
            ext_irq_zero_flag_reg <= ext_irq_zero_flag_next;
            irq_pin_one_reg <= ext_irq_pin_one_n_i;
            irq_pin_zero_reg <= ext_irq_pin_zero_n_i;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign timer_zero_overflow_flag_o = timer_zero_overflow_flag_reg;
    assign timer_one_overflow_flag_o = timer_one_overflow_flag_reg;
    assign ext_irq_zero_flag_o = ext_irq_zero_flag_reg;
    assign ext_irq_one_flag_o = ext_irq_one_flag_reg;

endmodule : dtc_top

// ===== bench/dtc_top_assertions.sv
module dtc_top_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic ext_irq_pin_zero_n_i,
    input wire logic ext_irq_pin_one_n_i,
    input wire logic vector_timer_zero_i,
    input wire logic vector_timer_one_i,
    input wire logic timer_zero_overflow_flag_o,
    input wire logic timer_one_overflow_flag_o,
    input wire logic ext_irq_zero_flag_o,
    input wire logic ext_irq_one_flag_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence
    a_one_wait_state: assert property (s_access |=> s_answer)
        else $error("bus answer not one wait state");
    a_error_answer: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0))
        else $error("error answer malformed");
    a_tmr0_flag_holds: assert property (
        timer_zero_overflow_flag_o && !vector_timer_zero_i && !(psel_i && pwrite_i) |=> timer_zero_overflow_flag_o)
        else $error("timer zero flag dropped");
    a_tmr1_flag_holds: assert property (
        timer_one_overflow_flag_o && !vector_timer_one_i && !(psel_i && pwrite_i) |=> timer_one_overflow_flag_o)
        else $error("timer one flag dropped");
    a_tmr0_vector_clears: assert property (timer_zero_overflow_flag_o && vector_timer_zero_i |=>
        !timer_zero_overflow_flag_o) else $error("timer zero flag not cleared");
    a_tmr1_vector_clears: assert property (timer_one_overflow_flag_o && vector_timer_one_i |=>
        !timer_one_overflow_flag_o) else $error("timer one flag not cleared");
    a_x0_fall_sets: assert property ($fell(ext_irq_pin_zero_n_i) |=> ext_irq_zero_flag_o)
        else $error("pin zero fall missed");
    a_x1_fall_sets: assert property ($fell(ext_irq_pin_one_n_i) |=> ext_irq_one_flag_o)
        else $error("pin one fall missed");
    a_reset_clears: assert property ($fell(rst_i) |-> !timer_zero_overflow_flag_o &&
        !timer_one_overflow_flag_o && !ext_irq_zero_flag_o && !ext_irq_one_flag_o) else $error("flags after reset");
endmodule : dtc_top_assertions

bind dtc_top dtc_top_assertions i_dtc_top_assertions (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ext_irq_pin_zero_n_i(ext_irq_pin_zero_n_i), .ext_irq_pin_one_n_i(ext_irq_pin_one_n_i),
    .vector_timer_zero_i(vector_timer_zero_i), .vector_timer_one_i(vector_timer_one_i),
    .timer_zero_overflow_flag_o(timer_zero_overflow_flag_o), .timer_one_overflow_flag_o(timer_one_overflow_flag_o),
    .ext_irq_zero_flag_o(ext_irq_zero_flag_o), .ext_irq_one_flag_o(ext_irq_one_flag_o));

// ===== bench/dtc_pin_model.sv
module dtc_pin_model (
    input wire logic clk_i,
    input wire logic [1:0] count_req_i,
    input wire logic [1:0] irq_req_n_i,
    output logic [1:0] count_pin_o,
    output logic [1:0] irq_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        count_pin_o = 2'h0;
        irq_pin_n_o = 2'h3;
    end
    // levels change only on an edge, so each is held at least one whole cycle
    always @(posedge clk_i)
    begin
        count_pin_o <= count_req_i;
        irq_pin_n_o <= irq_req_n_i;
    end
endmodule : dtc_pin_model

// ===== bench/dual_timer_counter_ext_irq_flags_tb.sv
module dual_timer_counter_ext_irq_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [3:0] vec = 4'h0;
    logic [3:0] flg;
    logic [1:0] cnt_req = 2'h0;
    logic [1:0] irq_req_n = 2'h3;
    logic [1:0] cnt_pin;
    logic [1:0] irq_pin_n;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    always #25 clk_i = ~clk_i;

    dtc_top i_dtc_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .count_pin_zero_i(cnt_pin[0]), .count_pin_one_i(cnt_pin[1]),
        .ext_irq_pin_zero_n_i(irq_pin_n[0]), .ext_irq_pin_one_n_i(irq_pin_n[1]),
        .vector_timer_zero_i(vec[0]), .vector_timer_one_i(vec[1]), .vector_ext_irq_zero_i(vec[2]),
        .vector_ext_irq_one_i(vec[3]), .timer_zero_overflow_flag_o(flg[0]), .timer_one_overflow_flag_o(flg[1]),
        .ext_irq_zero_flag_o(flg[2]), .ext_irq_one_flag_o(flg[3]));
    dtc_pin_model i_dtc_pin_model (.clk_i(clk_i), .count_req_i(cnt_req), .irq_req_n_i(irq_req_n),
        .count_pin_o(cnt_pin), .irq_pin_n_o(irq_pin_n));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wdata);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {2'h0, idx, 2'h0};
        pwdata_i <= {24'h0, wdata};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic pulse_vec(input logic [1:0] b);
        @(posedge clk_i);
        vec[b] <= 1'b1;
        @(posedge clk_i);
        vec[b] <= 1'b0;
        @(posedge clk_i);
    endtask : pulse_vec

    task automatic t_reset();
        apb(1'b0, 8'h88, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, 8'h89, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, 8'h80, 8'h00);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        $display("reset test done");
    endtask : t_reset

    // timer mode: run and gate commits are four edges apart, so four steps
    task automatic t_run(input logic t, input logic [7:0] mode, input logic [7:0] hi, input logic [7:0] lo,
        input int np, input logic [7:0] ehi, input logic [7:0] elo, input logic [7:0] m, input logic ef);
        irq_req_n <= 2'h0;
        apb(1'b1, 8'h89, t ? {mode[3:0], 4'h0} : mode);
        apb(1'b1, {7'h46, t}, hi);
        apb(1'b1, {7'h45, t}, lo);
        apb(1'b1, 8'h88, t ? 8'h40 : 8'h10);
        repeat (np)
        begin
            @(posedge clk_i);
            cnt_req[t] <= 1'b1;
            repeat (2) @(posedge clk_i);
            cnt_req[t] <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        apb(1'b1, 8'h89, t ? {mode[3:0] | 4'h8, 4'h0} : mode | 8'h08);
        apb(1'b0, {7'h46, t}, 8'h00);
        check(rd, {24'h0, ehi});
        apb(1'b0, {7'h45, t}, 8'h00);
        check(rd & {24'h0, m}, {24'h0, elo & m});
        check({31'h0, flg[t]}, {31'h0, ef});
        pulse_vec({1'b0, t});
        check({31'h0, flg[t]}, 32'h0);
        apb(1'b1, 8'h88, 8'h00);
        apb(1'b1, 8'h89, 8'h00);
        irq_req_n <= 2'h3;
        $display("run test done timer %0d mode %h", t, mode);
    endtask : t_run

    task automatic t_ext(input logic b);
        apb(1'b1, 8'h88, b ? 8'h04 : 8'h01);
        irq_req_n[b] <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0, flg[{1'b1, b}]}, 32'h1);
        irq_req_n[b] <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, flg[{1'b1, b}]}, 32'h1);
        pulse_vec({1'b1, b});
        check({31'h0, flg[{1'b1, b}]}, 32'h0);
        apb(1'b1, 8'h88, 8'h00);
        irq_req_n[b] <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({31'h0, flg[{1'b1, b}]}, 32'h1);
        pulse_vec({1'b1, b});
        check({31'h0, flg[{1'b1, b}]}, 32'h1);
        irq_req_n[b] <= 1'b1;
        repeat (3) @(posedge clk_i);
        check({31'h0, flg[{1'b1, b}]}, 32'h0);
        $display("external pin test done pin %0d", b);
    endtask : t_ext

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_run(1'b0, 8'h01, 8'hff, 8'hfe, 0, 8'h00, 8'h02, 8'hff, 1'b1);
        t_run(1'b1, 8'h01, 8'hff, 8'hfe, 0, 8'h00, 8'h02, 8'hff, 1'b1);
        t_run(1'b0, 8'h00, 8'hff, 8'h1e, 0, 8'h00, 8'h02, 8'h1f, 1'b1);
        t_run(1'b1, 8'h00, 8'h12, 8'h3c, 0, 8'h13, 8'h00, 8'h1f, 1'b0);
        t_run(1'b0, 8'h05, 8'h00, 8'h00, 3, 8'h00, 8'h03, 8'hff, 1'b0);
        t_run(1'b1, 8'h05, 8'hff, 8'hfe, 2, 8'h00, 8'h00, 8'hff, 1'b1);
        t_run(1'b1, 8'h02, 8'h10, 8'hfe, 0, 8'h10, 8'h12, 8'hff, 1'b1);
        t_run(1'b0, 8'h03, 8'h55, 8'hfe, 0, 8'h55, 8'h02, 8'hff, 1'b1);
        t_run(1'b1, 8'h03, 8'h12, 8'h34, 0, 8'h12, 8'h34, 8'hff, 1'b0);
        t_ext(1'b0);
        t_ext(1'b1);
        finish_test();
    end
endmodule : dual_timer_counter_ext_irq_flags_tb
